/* verilog/dwbl_pkg.sv */
// Constants and register map of the core wake-up and boot latch block
// Functional notes
// (R1) When device reset is released the boot-select pins are sampled and held in the boot config latch.
// (R2) No boot runs purely in hardware; the latched pins only select which boot-ROM mode is used.
// (R3) After reset the signal core is held in reset with its clock gated.
// (R4) Software first writes the first unlock key to the first unlock register.
// (R5) Software then writes the second unlock key to the second unlock register.
// (R6) Software writes a truncated boot vector into the host-1 config register; its low bits read as zero.
// (R7) Writing 3h to the next-state field requests the move from gated reset to enabled.
// (R8) Writing 1 to bit 1 of the transition command register starts the domain transition.
// (R9) Bit 1 of the transition status register is set while the transition runs and clears when done.
// (R10) The module status state field shows 3h once the module is enabled.
// (R11) Writing 1 to the local reset bit releases the core's local reset.
// (R12) One write of 103h to module control both requests enable and releases local reset.
// (R13) Unlock and vector steps are only needed after a reset; otherwise the sleep controller alone gates clocks.
// (R14) Host-1 config writes take effect only after both keys were written in order.
package dwbl_pkg;
  localparam logic [11:0] DWBL_OFS_BOOT_CONFIG_LATCH_REG  = 12'h0_000;
  localparam logic [11:0] DWBL_OFS_KEY0     = 12'h0_004;
  localparam logic [11:0] DWBL_OFS_KEY1     = 12'h0_008;
  localparam logic [11:0] DWBL_OFS_HOST1    = 12'h0_00C;
  localparam logic [11:0] DWBL_OFS_MDCTL    = 12'h0_010;
  localparam logic [11:0] DWBL_OFS_MDSTAT   = 12'h0_014;
  localparam logic [11:0] DWBL_OFS_DOMAIN_TRANSITION_CMD_REG    = 12'h0_018;
  localparam logic [11:0] DWBL_OFS_DOMAIN_TRANSITION_STATUS_REG   = 12'h0_01C;
  localparam logic [31:0] DWBL_KEY0_VAL     = 32'h83E7_0B13;
  localparam logic [31:0] DWBL_KEY1_VAL     = 32'h95A4_F1E0;
  localparam logic [31:0] DWBL_VEC_MASK     = 32'hFFFF_FC00;
  localparam logic [31:0] DWBL_VEC_RESET    = 32'h0000_0000;
  localparam logic [5:0]  DWBL_STATE_GATED  = 6'h0_0;
  localparam logic [5:0]  DWBL_STATE_ENABLE = 6'h0_3;
  localparam int          DWBL_NEXT_LSB     = 0;
  localparam int          DWBL_NEXT_W       = 5;
  localparam int          DWBL_LOCAL_RESET_RELEASE_BIT_BIT     = 8;
  localparam int          DWBL_GO_BIT       = 1;
  localparam int          DWBL_STATE_W      = 6;
  localparam int          DWBL_CLKON_BIT    = 8;
  localparam int          DWBL_LRSTS_BIT    = 9;
  localparam int          DWBL_TRANS_NS     = 160;
  localparam int          DWBL_CLK_NS       = 10;
  localparam int          DWBL_TRANS_CYC    = (DWBL_TRANS_NS + DWBL_CLK_NS - 1) / DWBL_CLK_NS;
  localparam int          DWBL_CNT_W        = 8;
  typedef enum logic [1:0] {DWBL_IDLE, DWBL_RUN} dwbl_tr_e;
endpackage : dwbl_pkg

/* verilog/dwbl_key_stage.sv */
// One step of the ordered unlock key chain
module dwbl_key_stage
  import dwbl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] key,
  input  wire logic        prev_ok,
  input  wire logic        clear,
  output logic             ok
);
  logic ok_ff;
  logic nxt_ok;
  // Wrong value relocks; key only counts after the earlier stage
  assign nxt_ok = clear ? 1'b0 : (wr ? (prev_ok && wdata == key) : ok_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ok_ff <= 1'b0;
    else          ok_ff <= nxt_ok;
  end
  assign ok = ok_ff;
endmodule : dwbl_key_stage

/* verilog/dwbl_wakeup.sv */
// Boot pin latch, unlock keys and core wake-up sequencer with APB slave
//
// Decided for this implementation: register access over APB and the register addresses.
module dwbl_wakeup
  import dwbl_pkg::*;
#(
  parameter int BOOT_W = 16
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [BOOT_W-1:0] boot_pins,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   core_clk_en,
  output logic                   core_rst_n,
  output logic [31:0]            core_boot_vector
);
  logic              acc;
  logic              wr;
  logic              rd;
  logic              hit_boot;
  logic              hit_key0;
  logic              hit_key1;
  logic              hit_host1;
  logic              hit_mdctl;
  logic              hit_mdstat;
  logic              hit_domain_transition_cmd_reg;
  logic              hit_domain_transition_status_reg;
  logic              hit_any;
  logic              key0_ok;
  logic              key1_ok;
  logic              key1_wr;
  logic              latch_done_ff;
  logic [BOOT_W-1:0] boot_cfg_ff;
  logic [31:0]       vec_ff;
  logic [DWBL_NEXT_W-1:0] next_ff;
  logic              local_reset_release_bit_rel_ff;
  logic [DWBL_STATE_W-1:0] state_ff;
  logic [DWBL_STATE_W-1:0] nxt_state;
  dwbl_tr_e          tr_ff;
  dwbl_tr_e          nxt_tr;
  logic [DWBL_CNT_W-1:0]   cnt_ff;
  logic [DWBL_CNT_W-1:0]   nxt_cnt;
  logic              go_wr;
  logic              busy;
  logic              want_en;
  logic [31:0]       rdata;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic              clk_en_ff;
  logic              rst_n_ff;

  // Access phase; slave answers one cycle later, so a two-cycle access phase
  assign acc        = psel && penable && !pready_ff;
  assign wr         = acc && pwrite;
  assign rd         = acc && !pwrite;
  assign hit_boot   = (paddr == DWBL_OFS_BOOT_CONFIG_LATCH_REG);
  assign hit_key0   = (paddr == DWBL_OFS_KEY0);
  assign hit_key1   = (paddr == DWBL_OFS_KEY1);
  assign hit_host1  = (paddr == DWBL_OFS_HOST1);
  assign hit_mdctl  = (paddr == DWBL_OFS_MDCTL);
  assign hit_mdstat = (paddr == DWBL_OFS_MDSTAT);
  assign hit_domain_transition_cmd_reg  = (paddr == DWBL_OFS_DOMAIN_TRANSITION_CMD_REG);
  assign hit_domain_transition_status_reg = (paddr == DWBL_OFS_DOMAIN_TRANSITION_STATUS_REG);
  assign hit_any    = hit_boot || hit_key0 || hit_key1 || hit_host1 ||
                      hit_mdctl || hit_mdstat || hit_domain_transition_cmd_reg || hit_domain_transition_status_reg;
  assign key1_wr    = wr && hit_key1;

  // (R4) first unlock key
  dwbl_key_stage u_key0 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr && (hit_key0 || hit_key1)),
    .wdata   (hit_key0 ? pwdata : DWBL_KEY0_VAL),
    .key     (DWBL_KEY0_VAL),
    .prev_ok (hit_key0 ? 1'b1 : key0_ok),
    .clear   (1'b0),
    .ok      (key0_ok)
  );
  // (R5) second key must follow the first
  dwbl_key_stage u_key1 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr && (hit_key1 || hit_key0)),
    .wdata   (hit_key1 ? pwdata : 32'h0000_0000),
    .key     (DWBL_KEY1_VAL),
    .prev_ok (key0_ok),
    .clear   (1'b0),
    .ok      (key1_ok)
  );

  // (R1) pins caught once, first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) latch_done_ff <= 1'b0;
    else          latch_done_ff <= 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)            boot_cfg_ff <= '0;
    else if (!latch_done_ff) boot_cfg_ff <= boot_pins;
  end

  // (R14) vector writes gated by unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                          vec_ff <= DWBL_VEC_RESET;
    else if (wr && hit_host1 && key1_ok)   vec_ff <= pwdata & DWBL_VEC_MASK;
  end

  // (R7) (R11) (R12) next-state and local reset in one word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_ff     <= '0;
      local_reset_release_bit_rel_ff <= 1'b0;
    end else if (wr && hit_mdctl) begin
      next_ff     <= pwdata[DWBL_NEXT_LSB +: DWBL_NEXT_W];
      local_reset_release_bit_rel_ff <= pwdata[DWBL_LOCAL_RESET_RELEASE_BIT_BIT];
    end
  end

  // (R8) go bit starts a transition
  assign go_wr   = wr && hit_domain_transition_cmd_reg && pwdata[DWBL_GO_BIT];
  assign busy    = (tr_ff == DWBL_RUN);
  assign want_en = (next_ff == DWBL_NEXT_W'(DWBL_STATE_ENABLE));

  always_comb begin
    nxt_tr    = tr_ff;
    nxt_cnt   = cnt_ff;
    nxt_state = state_ff;
    case (tr_ff)
      DWBL_IDLE: begin
        if (go_wr) begin
          nxt_tr  = DWBL_RUN;
          nxt_cnt = DWBL_CNT_W'(DWBL_TRANS_CYC - 1);
        end
      end
      DWBL_RUN: begin
        if (cnt_ff == '0) begin
          nxt_tr    = DWBL_IDLE;
          // (R10) state shows enable once done if next-state asked for enable, else gated
          nxt_state = want_en ? DWBL_STATE_ENABLE : DWBL_STATE_GATED;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: nxt_tr = DWBL_IDLE;
    endcase
  end

  // (R9) busy held while transition runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_ff    <= DWBL_IDLE;
      cnt_ff   <= '0;
      state_ff <= DWBL_STATE_GATED;
    end else begin
      tr_ff    <= nxt_tr;
      cnt_ff   <= nxt_cnt;
      state_ff <= nxt_state;
    end
  end

  // (R3) (R13) core gated until enabled, held in reset until enabled with local reset release bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      clk_en_ff <= (state_ff == DWBL_STATE_ENABLE);
      rst_n_ff  <= (state_ff == DWBL_STATE_ENABLE) && local_reset_release_bit_rel_ff;
    end
  end

  // (R2) pins only reported to boot ROM, never act directly
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_boot) begin
      rdata[BOOT_W-1:0] = boot_cfg_ff;
    end else if (hit_host1) begin
      rdata = vec_ff;
    end else if (hit_mdctl) begin
      rdata[DWBL_NEXT_LSB +: DWBL_NEXT_W] = next_ff;
      rdata[DWBL_LOCAL_RESET_RELEASE_BIT_BIT]                = local_reset_release_bit_rel_ff;
    end else if (hit_mdstat) begin
      rdata[DWBL_STATE_W-1:0] = state_ff;
      rdata[DWBL_CLKON_BIT]   = clk_en_ff;
      rdata[DWBL_LRSTS_BIT]   = rst_n_ff;
    end else if (hit_domain_transition_status_reg) begin
      rdata[DWBL_GO_BIT] = busy;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc && !hit_any;
      prdata_ff  <= rd ? rdata : 32'h0000_0000;
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign core_clk_en      = clk_en_ff;
  assign core_rst_n       = rst_n_ff;
  assign core_boot_vector = vec_ff;

  // Assertions
  sequence go_seq;
    go_wr && !busy;
  endsequence
  // Busy for the whole count, 16 cycles as two halves of 8
  sequence run_seq;
    busy [*8] ##1 busy [*8];
  endsequence

  // (R9) busy spans the transition
  busy_span_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_seq |=> run_seq ##1 !busy) else $error("busy length wrong");
  // (R10) enable reached after enable request
  state_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && cnt_ff == '0 && want_en) |=> state_ff == DWBL_STATE_ENABLE)
    else $error("state not enabled");
  // (R3) gated before enable
  gated_core_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff != DWBL_STATE_ENABLE) |=> !core_clk_en && !core_rst_n)
    else $error("core ran while gated");
  // (R11) reset release follows bit
  local_reset_release_bit_rel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == DWBL_STATE_ENABLE && local_reset_release_bit_rel_ff) |=> core_rst_n)
    else $error("local reset not released");
  // (R14) locked vector holds
  vec_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_host1 && !key1_ok) |=> $stable(vec_ff)) else $error("locked write took");
  // (R6) low vector bits zero
  vec_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (vec_ff & ~DWBL_VEC_MASK) == 32'h0000_0000) else $error("vector low bits set");
  // (R1) latch frozen after first edge
  boot_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    latch_done_ff |=> $stable(boot_cfg_ff)) else $error("boot latch changed");
  // (R12) combined write requests enable with reset released
  combo_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_mdctl && pwdata == 32'h0000_0103) |=> want_en && local_reset_release_bit_rel_ff)
    else $error("combined write lost");
  // (R8) go starts busy
  go_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_seq |=> busy) else $error("go ignored");

  // Bus answer is one cycle after the access
  bus_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc |=> pready) else $error("access not answered");

  // Answer stands one cycle only
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held too long");

  // Error only alongside ready
  slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");

  // Read data zero outside answer
  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000) else $error("stray read data");

  // (R1) pins caught at first edge
  boot_capture_a: assert property (@(posedge pclk) disable iff (!presetn) // (R1)
    !latch_done_ff |=> boot_cfg_ff == $past(boot_pins)) else $error("boot pins missed");

  // (R14) second key needs first
  key_order_a: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
    key1_ok |-> key0_ok) else $error("unlock out of order");

  // (R5) unlock only by right second key
  key1_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // (R5)
    $rose(key1_ok) |-> $past(key1_wr && key0_ok && pwdata == DWBL_KEY1_VAL))
    else $error("unlock without key");

  // (R6) unlocked write lands truncated
  vec_write_a: assert property (@(posedge pclk) disable iff (!presetn) // (R6)
    (wr && hit_host1 && key1_ok) |=> vec_ff == ($past(pwdata) & DWBL_VEC_MASK))
    else $error("vector write lost");

  // (R10) status only gated or enabled
  state_legal_a: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
    state_ff == DWBL_STATE_GATED || state_ff == DWBL_STATE_ENABLE)
    else $error("illegal module state");

  // (R9) (R10) state settles when busy ends
  busy_end_a: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
    ($fell(busy) && $past(want_en)) |-> state_ff == DWBL_STATE_ENABLE)
    else $error("state not set at end");

  // (R3) clock follows enabled state
  clk_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // (R3)
    state_ff == DWBL_STATE_ENABLE |=> core_clk_en) else $error("clock not enabled");

  // (R11) reset released only with clock
  rst_needs_clk_a: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
    core_rst_n |-> core_clk_en) else $error("reset released while gated");

  // (R8) go while busy does not restart
  go_busy_a: assert property (@(posedge pclk) disable iff (!presetn) // (R8)
    (go_wr && busy && cnt_ff != '0) |=> busy && cnt_ff == $past(cnt_ff) - 1'b1)
    else $error("go restarted transition");
endmodule : dwbl_wakeup

/* tb/test_dsp_wakeup_boot_latch.sv */
// Self-checking bench for the boot latch and core wake-up block
module test_dsp_wakeup_boot_latch
  import dwbl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } dwbl_row_s;

  logic        pclk;
  logic        presetn;
  logic [15:0] boot_pins;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        core_clk_en;
  logic        core_rst_n;
  logic [31:0] core_boot_vector;
  int          n_errors;
  int          n_tests;
  dwbl_row_s   rows [12];
  logic [31:0] rd;
  logic        er;

  dwbl_wakeup #(.BOOT_W(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .boot_pins(boot_pins), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_clk_en(core_clk_en), .core_rst_n(core_rst_n),
    .core_boot_vector(core_boot_vector)
  );

  always #5 pclk = ~pclk;

  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  // Entered just after an edge with psel low; leaves one idle edge behind
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    if (pready === 1'h1 || n >= 20) begin
      n_errors++;
      $display("MISMATCH pready expected pulse seen none");
      complete_run();
    end
  endtask : apb

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0000_0000);
    chk(nm, rd, x);
  endtask : rdc

  task automatic do_reset(input logic [15:0] pins);
    presetn   <= 1'h0;
    boot_pins <= pins;
    repeat (8) @(posedge pclk);
    presetn   <= 1'h1;
    repeat (2) @(posedge pclk);
    // Pins move after capture, so a late sample shows up
    boot_pins <= ~pins;
    @(posedge pclk);
  endtask : do_reset

  // Start transition, see busy set, poll it clear within a bound
  task automatic run_go(input logic [31:0] xstat);
    int i;
    apb(1'h1, DWBL_OFS_DOMAIN_TRANSITION_CMD_REG, 32'h0000_0002);
    rdc("busy set", DWBL_OFS_DOMAIN_TRANSITION_STATUS_REG, 32'h0000_0002);
    i = 0;
    while (rd[1] !== 1'h0 && i < 40) begin
      apb(1'h0, DWBL_OFS_DOMAIN_TRANSITION_STATUS_REG, 32'h0000_0000);
      i++;
    end
    chk("busy clear", rd, 32'h0000_0000);
    if (i >= 40) begin
      complete_run();
    end
    rdc("module status", DWBL_OFS_MDSTAT, xstat);
    chk("clock enable", {31'h0000_0000, core_clk_en}, 32'h0000_0001);
  endtask : run_go

  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    boot_pins = 16'h0000;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_errors = 0;
    n_tests = 0;
    rows = '{
      '{1'h0, DWBL_OFS_BOOT_CONFIG_LATCH_REG, 32'h0000_0000, 32'h0000_A5C3, 1'h0},
      '{1'h1, DWBL_OFS_HOST1, 32'h1234_5678, 32'h0000_0000, 1'h0},
      '{1'h0, DWBL_OFS_HOST1, 32'h0000_0000, 32'h0000_0000, 1'h0},
      '{1'h1, DWBL_OFS_KEY0, DWBL_KEY0_VAL, 32'h0000_0000, 1'h0},
      '{1'h1, DWBL_OFS_KEY1, DWBL_KEY1_VAL, 32'h0000_0000, 1'h0},
      '{1'h1, DWBL_OFS_HOST1, 32'h1234_5678, 32'h0000_0000, 1'h0},
      '{1'h0, DWBL_OFS_HOST1, 32'h0000_0000, 32'h1234_5678 & DWBL_VEC_MASK, 1'h0},
      '{1'h0, DWBL_OFS_KEY0, 32'h0000_0000, 32'h0000_0000, 1'h0},
      '{1'h0, DWBL_OFS_MDSTAT, 32'h0000_0000, 32'h0000_0000, 1'h0},
      '{1'h0, DWBL_OFS_DOMAIN_TRANSITION_STATUS_REG, 32'h0000_0000, 32'h0000_0000, 1'h0},
      '{1'h0, 12'h020, 32'h0000_0000, 32'h0000_0000, 1'h1},
      '{1'h1, 12'h024, 32'hFFFF_FFFF, 32'h0000_0000, 1'h1}
    };
    do_reset(16'hA5C3);
    foreach (rows[k]) begin
      apb(rows[k].wr, rows[k].a, rows[k].d);
      if (rows[k].wr === 1'h0) begin
        chk("row read", rd, rows[k].x);
      end
      chk("row error", {31'h0000_0000, er}, {31'h0000_0000, rows[k].e});
    end
    chk("vector port", core_boot_vector, 32'h1234_5678 & DWBL_VEC_MASK);
    chk("gated reset", {30'h0000_0000, core_clk_en, core_rst_n}, 32'h0000_0000);
    // Wrong first key relocks the vector register
    apb(1'h1, DWBL_OFS_KEY0, 32'h0000_0000);
    apb(1'h1, DWBL_OFS_HOST1, 32'hFFFF_FFFF);
    rdc("relocked", DWBL_OFS_HOST1, 32'h1234_5678 & DWBL_VEC_MASK);
    // Enable only, local reset still held
    apb(1'h1, DWBL_OFS_MDCTL, 32'h0000_0003);
    run_go(32'h0000_0103);
    chk("still in reset", {31'h0000_0000, core_rst_n}, 32'h0000_0000);
    apb(1'h1, DWBL_OFS_MDCTL, 32'h0000_0103);
    rdc("status after release", DWBL_OFS_MDSTAT, 32'h0000_0303);
    chk("reset released", {31'h0000_0000, core_rst_n}, 32'h0000_0001);
    // Second reset: new pins latched, keys needed again
    do_reset(16'h1E0F);
    rdc("boot relatch", DWBL_OFS_BOOT_CONFIG_LATCH_REG, 32'h0000_1E0F);
    chk("vector cleared", core_boot_vector, DWBL_VEC_RESET);
    apb(1'h1, DWBL_OFS_HOST1, 32'hABCD_EF00);
    rdc("locked after reset", DWBL_OFS_HOST1, DWBL_VEC_RESET);
    apb(1'h1, DWBL_OFS_MDCTL, 32'h0000_0103);
    run_go(32'h0000_0303);
    chk("merged release", {31'h0000_0000, core_rst_n}, 32'h0000_0001);
    complete_run();
  end
endmodule : test_dsp_wakeup_boot_latch
